//--- rtl/obcd_map.svh
/*
 Offsets-free constant map for the option byte decoder: field positions,
 reset values and timing counts. Assumes inclusion from design files only.
*/
`ifndef OBCD_MAP_SVH
`define OBCD_MAP_SVH
`define OBCD_BYTE_W 8
`define OBCD_ERASED 8'hff
`define OBCD_CLEARED 8'h00
`define OBCD_RSVD_MASK 8'hfc
`define OBCD_PKG_BIT 1
`define OBCD_PROT_BIT 0
`define OBCD_CF_BIT 7
`define OBCD_OSC_HI 6
`define OBCD_OSC_LO 4
`define OBCD_LVD_HI 3
`define OBCD_LVD_LO 2
`define OBCD_HALT_BIT 1
`define OBCD_WDG_BIT 0
`define OBCD_ERASE_NS 100
`define OBCD_CLK_NS 10
`define OBCD_ERASE_CYC ((`OBCD_ERASE_NS + `OBCD_CLK_NS - 1) / `OBCD_CLK_NS)
`endif

//--- rtl/obcd_pkg.sv
/*
 Types shared by the option byte decoder. Assumes the map header for numbers.
*/
package obcd_pkg;
   typedef enum logic [2:0] {
      OBCD_OSC_HS,
      OBCD_OSC_MHS,
      OBCD_OSC_MLS,
      OBCD_OSC_LS,
      OBCD_OSC_EXT_NO,
      OBCD_OSC_EXT_RC,
      OBCD_OSC_INT_RC,
      OBCD_OSC_EXT_CLK
   } obcd_osc_t;
   typedef enum logic [1:0] {
      OBCD_LVD_LOW,
      OBCD_LVD_MED,
      OBCD_LVD_HIGH,
      OBCD_LVD_OFF
   } obcd_lvd_t;
   typedef enum logic [1:0] {
      OBCD_ST_IDLE,
      OBCD_ST_ERASE,
      OBCD_ST_DONE
   } obcd_state_t;
endpackage

//--- rtl/obcd_decode.sv
/*
 Pure field decoder for the two option bytes.
 Assumes byte values are already latched and stable.
*/
`timescale 1ns/1ps
`include "obcd_map.svh"
module obcd_decode
   import obcd_pkg::*;
(
   input wire logic [7:0] pkg_byte,
   input wire logic [7:0] clk_byte,
   output logic pin_count_large,
   output logic readout_protect,
   output logic clock_filter_off,
   output obcd_osc_t clock_source_select,
   output obcd_lvd_t brownout_level,
   output logic halt_reset_on_watchdog,
   output logic watchdog_soft_enable
);
   // Field extraction; enum orders match the raw encodings.
   always_comb begin
      pin_count_large = pkg_byte[`OBCD_PKG_BIT];
      readout_protect = pkg_byte[`OBCD_PROT_BIT];
      clock_filter_off = clk_byte[`OBCD_CF_BIT];
      clock_source_select = obcd_osc_t'(clk_byte[`OBCD_OSC_HI:`OBCD_OSC_LO]);
      brownout_level = obcd_lvd_t'(clk_byte[`OBCD_LVD_HI:`OBCD_LVD_LO]);
      halt_reset_on_watchdog = clk_byte[`OBCD_HALT_BIT];
      watchdog_soft_enable = clk_byte[`OBCD_WDG_BIT];
   end
endmodule

//--- rtl/obcd_top.sv
/*
 Option byte store and configuration decoder. Holds the two non-volatile
 option bytes, accepts writes only in programming mode, erases on clearing
 the protection bit and drives latched configuration to other units.
 Assumes a programming port synchronous to clock and non-volatile retention
 modelled by the stored registers across device reset.
*/
`timescale 1ns/1ps
`include "obcd_map.svh"
// Functional notes
// - Byte 1 bit 1 selects small (0) or large (1) package variant.
// - Byte 1 bit 0 set blocks external program memory reads.
// - Clearing protection erases whole memory, option bytes included, to zero.
// - Unprogrammed parts hold all ones, so options default to one.
// - Option bytes are reachable only in programming mode, not mapped.
// - Byte 2 bit 7 low enables clock filter, high disables it.
// - Byte 2 bits 6:4 select main oscillator source.
// - Byte 2 bits 3:2 select brownout threshold or off.
// - Byte 2 bit 1 set makes halt with watchdog active reset.
// - Byte 2 bit 0 low runs watchdog always; high waits for software.
// - Factory-coded parts use fixed constant options, unchangeable by programming.
module obcd_top
   import obcd_pkg::*;
#(
   parameter bit FACTORY_CODED = 1'b0,
   parameter logic [7:0] FACTORY_BYTE1 = 8'hff,
   parameter logic [7:0] FACTORY_BYTE2 = 8'hff,
   parameter int ERASE_CYCLES = `OBCD_ERASE_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic prog_mode,
   input wire logic prog_wr,
   input wire logic prog_sel,
   input wire logic [7:0] prog_wdata,
   input wire logic prog_rd,
   output logic [7:0] prog_rdata,
   output logic prog_busy,
   output logic mem_erase,
   output logic pin_count_large,
   output logic readout_protect,
   output logic clock_filter_off,
   output obcd_osc_t clock_source_select,
   output obcd_lvd_t brownout_level,
   output logic halt_reset_on_watchdog,
   output logic watchdog_soft_enable
);
   localparam int CW = 8;

   // Non-volatile store, latched configuration and erase sequencer.
   // The store starts erased at power-on, as an unprogrammed part does.
   logic [7:0] nv1_r = `OBCD_ERASED;
   logic [7:0] nv2_r = `OBCD_ERASED;
   logic [7:0] nv1_nxt, nv2_nxt;
   logic [7:0] lat1_r, lat1_nxt, lat2_r, lat2_nxt;
   logic loaded_r, loaded_nxt;
   obcd_state_t st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic busy_r, busy_nxt, erase_r, erase_nxt;
   logic [7:0] eff1, eff2;
   logic d_pkg, d_prot, d_cf, d_halt, d_wdg;
   obcd_osc_t d_osc;
   obcd_lvd_t d_lvd;
   logic wr_ok;
   logic pkg_large_r, prot_r, cf_off_r, halt_r, wdg_r;
   obcd_osc_t osc_r;
   obcd_lvd_t lvd_r;

   // Factory parts ignore the stored bytes and use constants.
   assign eff1 = FACTORY_CODED ? FACTORY_BYTE1 : nv1_r;
   assign eff2 = FACTORY_CODED ? FACTORY_BYTE2 : nv2_r;
   // Writes count only in programming mode and not in factory parts.
   assign wr_ok = prog_mode && prog_wr && !busy_r && !FACTORY_CODED;

   // Store update, erase sequencing and programmer readback.
   always_comb begin
      nv1_nxt = nv1_r;
      nv2_nxt = nv2_r;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      erase_nxt = 1'b0;
      rdata_nxt = rdata_r;
      unique case (st_r)
         OBCD_ST_IDLE: begin
            if (wr_ok) begin
               if (!prog_sel) begin
                  // Reserved bits are forced high in case the tool slips.
                  nv1_nxt = prog_wdata | `OBCD_RSVD_MASK;
                  if (nv1_r[`OBCD_PROT_BIT] && !prog_wdata[`OBCD_PROT_BIT]) begin
                     st_nxt = OBCD_ST_ERASE;
                     cnt_nxt = CW'(ERASE_CYCLES - 1);
                     busy_nxt = 1'b1;
                     erase_nxt = 1'b1;
                  end
               end else begin
                  nv2_nxt = prog_wdata;
               end
            end
         end
         OBCD_ST_ERASE: begin
            erase_nxt = 1'b1;
            if (cnt_r == '0) begin
               nv1_nxt = `OBCD_CLEARED;
               nv2_nxt = `OBCD_CLEARED;
               st_nxt = OBCD_ST_DONE;
               erase_nxt = 1'b0;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         OBCD_ST_DONE: begin
            busy_nxt = 1'b0;
            st_nxt = OBCD_ST_IDLE;
         end
      endcase
      // Readback only in programming mode; protection does not hide options.
      if (prog_mode && prog_rd) begin
         rdata_nxt = prog_sel ? eff2 : eff1;
      end else if (!prog_mode) begin
         rdata_nxt = 8'h00;
      end
   end

   // Latch the effective bytes once at the first enabled edge after reset.
   always_comb begin
      lat1_nxt = lat1_r;
      lat2_nxt = lat2_r;
      loaded_nxt = loaded_r;
      if (!loaded_r) begin
         lat1_nxt = eff1;
         lat2_nxt = eff2;
         loaded_nxt = 1'b1;
      end
   end

   obcd_decode u_dec (
      .pkg_byte(lat1_r),
      .clk_byte(lat2_r),
      .pin_count_large(d_pkg),
      .readout_protect(d_prot),
      .clock_filter_off(d_cf),
      .clock_source_select(d_osc),
      .brownout_level(d_lvd),
      .halt_reset_on_watchdog(d_halt),
      .watchdog_soft_enable(d_wdg)
   );

   // Store registers survive device reset, standing in for non-volatile cells.
   // Giving them no reset branch is what keeps programmed options across resets.
   always_ff @(posedge clock) begin
      if (clk_en) begin
         nv1_r <= nv1_nxt;
         nv2_r <= nv2_nxt;
      end
   end

   // Control, latch and output registers.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= OBCD_ST_IDLE;
         cnt_r <= '0;
         busy_r <= 1'b0;
         erase_r <= 1'b0;
         rdata_r <= 8'h00;
         lat1_r <= `OBCD_ERASED;
         lat2_r <= `OBCD_ERASED;
         loaded_r <= 1'b0;
         pkg_large_r <= 1'b1;
         prot_r <= 1'b1;
         cf_off_r <= 1'b1;
         osc_r <= OBCD_OSC_EXT_CLK;
         lvd_r <= OBCD_LVD_OFF;
         halt_r <= 1'b1;
         wdg_r <= 1'b1;
      end else if (clk_en) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         erase_r <= erase_nxt;
         rdata_r <= rdata_nxt;
         lat1_r <= lat1_nxt;
         lat2_r <= lat2_nxt;
         loaded_r <= loaded_nxt;
         pkg_large_r <= d_pkg;
         prot_r <= d_prot;
         cf_off_r <= d_cf;
         osc_r <= d_osc;
         lvd_r <= d_lvd;
         halt_r <= d_halt;
         wdg_r <= d_wdg;
      end
   end

   assign prog_rdata = rdata_r;
   assign prog_busy = busy_r;
   assign mem_erase = erase_r;
   assign pin_count_large = pkg_large_r;
   assign readout_protect = prot_r;
   assign clock_filter_off = cf_off_r;
   assign clock_source_select = osc_r;
   assign brownout_level = lvd_r;
   assign halt_reset_on_watchdog = halt_r;
   assign watchdog_soft_enable = wdg_r;

   // Once loaded, the latched bytes never move until the next reset.
   a_latch_hold: assert property (@(posedge clock) disable iff (rst)
      $past(loaded_r) && loaded_r |-> $stable(lat1_r) && $stable(lat2_r))
      else $error("latched option bytes changed");
   // Reserved bits of the stored first byte read high in idle unless an erase has cleared the byte.
   a_rsvd_ones: assert property (@(posedge clock) disable iff (rst)
      st_r == OBCD_ST_IDLE && !FACTORY_CODED && nv1_r != `OBCD_CLEARED
      |-> (nv1_r & `OBCD_RSVD_MASK) == `OBCD_RSVD_MASK)
      else $error("reserved option bits not high");
   // Clearing protection starts an erase on the next enabled edge.
   a_erase_start: assert property (@(posedge clock) disable iff (rst)
      clk_en && wr_ok && !prog_sel && nv1_r[0] && !prog_wdata[0]
      |=> st_r == OBCD_ST_ERASE && busy_r)
      else $error("erase not started");
   // Leaving the erase state leaves both bytes at zero.
   a_erase_zero: assert property (@(posedge clock) disable iff (rst)
      st_r == OBCD_ST_ERASE && clk_en && cnt_r == '0
      |=> nv1_r == `OBCD_CLEARED && nv2_r == `OBCD_CLEARED)
      else $error("erase left nonzero bytes");
   // Outside programming mode the store cannot change except by erase.
   a_no_prog_wr: assert property (@(posedge clock) disable iff (rst)
      !prog_mode && st_r == OBCD_ST_IDLE |=> $stable(nv1_r) && $stable(nv2_r))
      else $error("option byte written outside programming mode");
   // Readback is zero outside programming mode.
   a_rd_gated: assert property (@(posedge clock) disable iff (rst)
      clk_en && !prog_mode |=> prog_rdata == 8'h00)
      else $error("readback visible outside programming mode");
   // Factory parts present the fixed constants on their protection, package, filter and watchdog outputs, whatever is written.
   a_factory_fix: assert property (@(posedge clock) disable iff (rst)
      FACTORY_CODED && loaded_r && $past(loaded_r) && $past(clk_en)
      |-> readout_protect == FACTORY_BYTE1[`OBCD_PROT_BIT]
      && pin_count_large == FACTORY_BYTE1[`OBCD_PKG_BIT]
      && clock_filter_off == FACTORY_BYTE2[`OBCD_CF_BIT]
      && watchdog_soft_enable == FACTORY_BYTE2[`OBCD_WDG_BIT])
      else $error("factory options not fixed");
   // Outputs follow the latched bytes one enabled edge after loading.
   a_out_decode: assert property (@(posedge clock) disable iff (rst)
      loaded_r && $past(loaded_r) && $past(clk_en) |->
      readout_protect == lat1_r[0] && pin_count_large == lat1_r[1]
      && clock_filter_off == lat2_r[7] && watchdog_soft_enable == lat2_r[0]
      && halt_reset_on_watchdog == lat2_r[1]
      && clock_source_select == obcd_osc_t'(lat2_r[6:4])
      && brownout_level == obcd_lvd_t'(lat2_r[3:2]))
      else $error("decoded outputs disagree with latched bytes");
   // An accepted first-byte write lands with its reserved bits forced high.
   a_wr1_lands: assert property (@(posedge clock) disable iff (rst)
      clk_en && wr_ok && !prog_sel
      |=> nv1_r == ($past(prog_wdata) | `OBCD_RSVD_MASK))
      else $error("first option byte write lost");
   // An accepted second-byte write lands exactly as written.
   a_wr2_lands: assert property (@(posedge clock) disable iff (rst)
      clk_en && wr_ok && prog_sel
      |=> nv2_r == $past(prog_wdata))
      else $error("second option byte write lost");
   // While the erase counts down no write reaches the store.
   a_busy_block: assert property (@(posedge clock) disable iff (rst)
      clk_en && st_r == OBCD_ST_ERASE && cnt_r != '0
      |=> $stable(nv1_r) && $stable(nv2_r))
      else $error("store changed during erase");
   // The erase marker never shows without the busy flag.
   a_erase_flag: assert property (@(posedge clock) disable iff (rst)
      mem_erase |-> prog_busy && st_r != OBCD_ST_IDLE)
      else $error("erase marker without busy");
   // The closing step of an erase frees the programming port.
   a_erase_done: assert property (@(posedge clock) disable iff (rst)
      clk_en && st_r == OBCD_ST_DONE
      |=> !prog_busy && !mem_erase && st_r == OBCD_ST_IDLE)
      else $error("erase did not finish");
   // Before the first enabled edge after reset the outputs show an erased part.
   a_reset_blank: assert property (@(posedge clock) disable iff (rst)
      !loaded_r |-> readout_protect && pin_count_large && clock_filter_off
      && halt_reset_on_watchdog && watchdog_soft_enable
      && clock_source_select == OBCD_OSC_EXT_CLK && brownout_level == OBCD_LVD_OFF)
      else $error("outputs after reset not at erased values");
   // A read strobe on the first byte answers with it at the next edge.
   a_rd_first: assert property (@(posedge clock) disable iff (rst)
      clk_en && prog_mode && prog_rd && !prog_sel |=> prog_rdata == $past(eff1))
      else $error("first byte readback wrong");
   // A read strobe on the second byte answers with it at the next edge.
   a_rd_second: assert property (@(posedge clock) disable iff (rst)
      clk_en && prog_mode && prog_rd && prog_sel |=> prog_rdata == $past(eff2))
      else $error("second byte readback wrong");
   // Between read strobes in programming mode the answer stands unchanged.
   a_rd_hold: assert property (@(posedge clock) disable iff (rst)
      clk_en && prog_mode && !prog_rd |=> $stable(prog_rdata))
      else $error("readback changed without a read");
   // With the clock enable low at the last edge, the protection, brownout, busy, erase and readback outputs may not have moved.
   a_freeze_outs: assert property (@(posedge clock) disable iff (rst)
      !$past(clk_en) |-> $stable(readout_protect) && $stable(brownout_level)
      && $stable(prog_busy) && $stable(mem_erase) && $stable(prog_rdata))
      else $error("state moved while the clock enable was low");
endmodule

//--- tb/obcd_prog_tool.sv
/*
 Behavioural programming tool for the option byte store.
 Assumes the store samples on the rising edge; the tool drives on the falling one.
*/
`timescale 1ns/1ps
module obcd_prog_tool (
   input wire logic clock,
   input wire logic [7:0] prog_rdata,
   output logic prog_mode,
   output logic prog_wr,
   output logic prog_sel,
   output logic [7:0] prog_wdata,
   output logic prog_rd
);
   // Idle values at time zero.
   initial begin
      prog_mode = 1'b0;
      prog_wr = 1'b0;
      prog_rd = 1'b0;
      prog_sel = 1'b0;
      prog_wdata = 8'h5a;
   end

   // Enters or leaves programming mode, the only way to reach the bytes.
   task automatic set_mode(input logic on);
      @(negedge clock);
      prog_mode = on;
   endtask

   // One write strobe; the data line is scrambled once the strobe is gone.
   task automatic write(input logic sel, input logic [7:0] data);
      @(negedge clock);
      prog_sel = sel;
      prog_wdata = sel ? data : (data | 8'hfc);
      prog_wr = 1'b1;
      @(negedge clock);
      prog_wr = 1'b0;
      prog_wdata = ~prog_wdata;
   endtask

   // One read strobe; the answer is registered by the next rising edge.
   task automatic read(input logic sel, output logic [7:0] data);
      @(negedge clock);
      prog_sel = sel;
      prog_rd = 1'b1;
      @(negedge clock);
      prog_rd = 1'b0;
      data = prog_rdata;
   endtask
endmodule

//--- tb/tb_top.sv
/*
 Self-checking bench for the option byte decoder, with a user part and a factory part.
 Assumes both parts share one programming tool and one clock.
*/
`timescale 1ns/1ps
module tb_top;
   localparam int ERASE_N = 6;
   logic clock, rst, clk_en, prog_mode, prog_wr, prog_sel, prog_rd, prog_busy, mem_erase;
   logic r_busy, r_erase;
   logic [7:0] r_rdata;
   int busy_seen, erase_seen;
   logic [7:0] prog_wdata, prog_rdata, b1, b2, n1, n2, d;
   logic pin, prot, cf, halt, wdg, r_pin, r_prot, r_cf, r_halt, r_wdg;
   obcd_pkg::obcd_osc_t osc, r_osc;
   obcd_pkg::obcd_lvd_t lvd, r_lvd;
   logic [9:0] cfg, rom_cfg;
   int error_cnt, comparisons, n;

   // Configuration outputs packed in option bit order.
   assign cfg = {pin, prot, cf, osc, lvd, halt, wdg};
   assign rom_cfg = {r_pin, r_prot, r_cf, r_osc, r_lvd, r_halt, r_wdg};

   obcd_top #(.ERASE_CYCLES(ERASE_N)) dut (.clock(clock), .rst(rst), .clk_en(clk_en),
      .prog_mode(prog_mode), .prog_wr(prog_wr), .prog_sel(prog_sel),
      .prog_wdata(prog_wdata), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
      .prog_busy(prog_busy), .mem_erase(mem_erase), .pin_count_large(pin),
      .readout_protect(prot), .clock_filter_off(cf), .clock_source_select(osc),
      .brownout_level(lvd), .halt_reset_on_watchdog(halt), .watchdog_soft_enable(wdg));
   obcd_top #(.FACTORY_CODED(1'b1), .FACTORY_BYTE1(8'hfd), .FACTORY_BYTE2(8'h5a)) dut_rom (
      .clock(clock), .rst(rst), .clk_en(clk_en), .prog_mode(prog_mode), .prog_wr(prog_wr),
      .prog_sel(prog_sel), .prog_wdata(prog_wdata), .prog_rd(prog_rd), .prog_rdata(r_rdata),
      .prog_busy(r_busy), .mem_erase(r_erase), .pin_count_large(r_pin), .readout_protect(r_prot),
      .clock_filter_off(r_cf), .clock_source_select(r_osc), .brownout_level(r_lvd),
      .halt_reset_on_watchdog(r_halt), .watchdog_soft_enable(r_wdg));
   obcd_prog_tool tool (.clock(clock), .prog_rdata(prog_rdata), .prog_mode(prog_mode),
      .prog_wr(prog_wr), .prog_sel(prog_sel), .prog_wdata(prog_wdata), .prog_rd(prog_rd));

   // Counts the falling edges at which the erase flags stand, for the length checks.
   always @(negedge clock) begin
      if (prog_busy === 1'b1) begin
         busy_seen <= busy_seen + 1;
      end
      if (mem_erase === 1'b1) begin
         erase_seen <= erase_seen + 1;
      end
   end

   // Decoded outputs are the option bits themselves, so expectation is a bit pick.
   function automatic logic [9:0] exp_cfg(input logic [7:0] o1, input logic [7:0] o2);
      return {o1[1:0], o2};
   endfunction

   task automatic check_cfg(input string what, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Pulses reset, then leaves room for the latch and decode edges.
   task automatic do_reset(input int len);
      @(negedge clock);
      rst = 1'b1;
      repeat (len) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Free-running clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Cuts a hang short; the whole run needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end

   // Main sequence: blank part, random options, refused access, erase.
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      void'($urandom(35));
      do_reset(12);
      check_cfg("cfg blank", exp_cfg(8'hff, 8'hff), cfg);
      check_cfg("rom cfg", exp_cfg(8'hfd, 8'h5a), rom_cfg);
      tool.set_mode(1'b1);
      tool.read(1'b1, d);
      check_byte("byte2 blank", 8'hff, d);
      b1 = 8'hff;
      b2 = 8'hff;
      // Each pass steps the oscillator and the brownout codes through all their values.
      for (int i = 0; i < 8; i++) begin
         n1 = 8'($urandom()) | 8'h01;
         n2 = (8'($urandom()) & 8'h83) | 8'(i << 4) | 8'((i % 4) << 2);
         tool.write(1'b0, n1);
         tool.write(1'b1, n2);
         tool.read(1'b0, d);
         check_byte("byte1", n1 | 8'hfc, d);
         check_byte("rom byte1", 8'hfd, r_rdata);
         tool.read(1'b1, d);
         check_byte("byte2", n2, d);
         check_byte("rom byte2", 8'h5a, r_rdata);
         check_cfg("cfg held", exp_cfg(b1, b2), cfg);
         b1 = n1 | 8'hfc;
         b2 = n2;
         do_reset(2);
         check_cfg("cfg decoded", exp_cfg(b1, b2), cfg);
      end
      // With the clock enable low nothing moves: neither a write nor the latch after reset.
      @(negedge clock);
      clk_en = 1'b0;
      tool.write(1'b1, ~b2);
      do_reset(2);
      check_cfg("cfg frozen", exp_cfg(8'hff, 8'hff), cfg);
      clk_en = 1'b1;
      repeat (3) @(negedge clock);
      check_cfg("cfg resumed", exp_cfg(b1, b2), cfg);
      check_cfg("rom cfg fixed", exp_cfg(8'hfd, 8'h5a), rom_cfg);
      tool.set_mode(1'b0);
      tool.write(1'b1, ~b2);
      tool.read(1'b1, d);
      check_byte("read outside mode", 8'h00, d);
      tool.set_mode(1'b1);
      tool.read(1'b1, d);
      check_byte("byte2 kept", b2, d);
      // Clearing the protection bit starts the erase; a write meanwhile is dropped.
      tool.write(1'b0, 8'hfe);
      check_byte("erase start", 8'h03, {6'h00, prog_busy, mem_erase});
      check_byte("rom no erase", 8'h00, {6'h00, r_busy, r_erase});
      tool.write(1'b1, 8'h33);
      n = 0;
      while (prog_busy !== 1'b0 && n < 50) begin
         @(negedge clock);
         n++;
      end
      check_byte("erase end", 8'h00, {6'h00, prog_busy, mem_erase});
      check_byte("busy length", 8'(ERASE_N + 1), 8'(busy_seen));
      check_byte("erase length", 8'(ERASE_N), 8'(erase_seen));
      tool.read(1'b0, d);
      check_byte("byte1 erased", 8'h00, d);
      tool.read(1'b1, d);
      check_byte("byte2 erased", 8'h00, d);
      do_reset(2);
      check_cfg("cfg erased", exp_cfg(8'h00, 8'h00), cfg);
      wrap_up();
   end
endmodule
